// [common/sfl_defines.svh]
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH

`define SFL_CMD_SANITIZE 8'hb4
`define SFL_FEAT_STATUS 16'h0000
`define SFL_FEAT_FREEZE 16'h0020
`define SFL_FEAT_OVERWRITE 16'h0014
`define SFL_FEAT_CRYPTO 16'h0011

`define SFL_ERRC_NONE 8'h00
`define SFL_ERRC_UNSANITIZED 8'h01
`define SFL_ERRC_BAD_FEATURE 8'h02
`define SFL_ERRC_FROZEN 8'h03

`define SFL_SC_DONE_BIT 15
`define SFL_SC_RUN_BIT 14
`define SFL_SC_FROZEN_BIT 13
`define SFL_SC_FAILMODE_BIT 4
`define SFL_SC_CLEAR_BIT 0

`define SFL_ERR_ABORT_BIT 2
`define SFL_ST_BUSY_BIT 7
`define SFL_ST_READY_BIT 6
`define SFL_ST_SEEK_BIT 4
`define SFL_ST_ERR_BIT 0

`define SFL_PROGRESS_IDLE 16'hffff
`define SFL_PROG_STEP 16'h0100

`define SFL_CLK_PERIOD_NS 50
`define SFL_TICK_PERIOD_NS 1000
`define SFL_TICK_CYCLES ((`SFL_TICK_PERIOD_NS + `SFL_CLK_PERIOD_NS - 1) / `SFL_CLK_PERIOD_NS)

`endif

// [common/sfl_pkg.sv]
package sfl_pkg;

    typedef enum logic [2:0] {
        sanitize_idle_state,
        sanitize_frozen_state,
        sanitize_operation_state,
        sanitize_failed_state,
        sanitize_succeeded_state
    } sfl_state_type;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] feature;
        logic [15:0] count;
    } sfl_cmd_type;

    typedef struct packed {
        logic [7:0] commandStatusFlags;
        logic [7:0] commandErrorFlags;
        logic [15:0] secCount;
        logic [7:0] secNum;
        logic [7:0] cylLow;
    } sfl_resp_type;

endpackage

// [logic/sfl_sanitize_engine.sv]
`timescale 1ns/1ps
`include "sfl_defines.svh"

module sfl_sanitize_engine #(
    parameter int TICK_CYCLES = `SFL_TICK_CYCLES,
    parameter logic [15:0] PROG_STEP = `SFL_PROG_STEP
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic mediaFault,
    output logic busy_q,
    output logic done_q,
    output logic failed_q,
    output logic [15:0] progress_q
);

    logic [15:0] divCnt_q;
    logic tick_q;
    logic [16:0] progSum;

    assign progSum = {1'b0, progress_q} + {1'b0, PROG_STEP};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (divCnt_q == 16'(TICK_CYCLES - 1)) begin
            divCnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            divCnt_q <= divCnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // Progress wraps past 0xffff exactly when the pass is complete
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            progress_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                progress_q <= 16'h0000;
            end else if (busy_q && tick_q) begin
                if (progSum[16]) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    progress_q <= 16'h0000;
                end else begin
                    progress_q <= progSum[15:0];
                end
            end
        end
    end

    // A fault anywhere in the pass marks the whole operation failed
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            failed_q <= 1'b0;
        end else if (start) begin
            failed_q <= 1'b0;
        end else if (busy_q && mediaFault) begin
            failed_q <= 1'b1;
        end
    end

endmodule

// [logic/sfl_sanitize_ctrl.sv]
// What this block does
// - Sanitize commands other than status abort once freeze-lock completed, until the next power-on or hardware reset.
// - Failed state after a command with failed_state_exit_allowed clear aborts sanitize commands, except a status without the clear bit.
// - Failed state aborts an overwrite command whose failed_state_exit_allowed bit is one.
// - Error code in sector number: 00h not reported, 01h unsanitized sectors left.
// - Code 02h bad feature value, 03h frozen; 04h to FFh reserved.
// - Command B4h with feature 0020h decodes as sanitize freeze-lock.
// - Freeze-lock moves the state machine into the frozen state.
// - While frozen, every sanitize command except status is aborted.
// - Frozen returns to idle only on power-on or hardware reset.
// - Sector count bit 15 is one on success, zero on entering operation.
// - Completed-without-error flag survives power-on resets via backing store.
// - Sector count bit 14 shows operation running, bit 13 shows frozen.
// - Progress numerator over 65536: high byte cylinder low, low byte sector number.
// - Progress reads FFFFh when no sanitize operation is running and no error code takes the sector number.
// - Failed to idle on status with clear bit when failed_state_exit_allowed was one.
`timescale 1ns/1ps
`include "sfl_defines.svh"

module sfl_sanitize_ctrl
    import sfl_pkg::*;
#(
    parameter int TICK_CYCLES = `SFL_TICK_CYCLES,
    parameter logic [15:0] PROG_STEP = `SFL_PROG_STEP
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hwReset,
    input wire logic cmdValid,
    input wire sfl_cmd_type cmd,
    input wire logic mediaFault,
    input wire logic nvCompletedIn,
    output logic cmdDone_q,
    output sfl_resp_type resp_q,
    output logic completedOk_q
);

    sfl_state_type state_q, state_d;
    logic exitAllowed_q;
    logic nvLoaded_q;
    logic engBusy, engDone, engFailed;
    logic [15:0] engProgress;
    logic isSan, isStatus, isFreeze, isOverwrite, isCrypto, isStart, knownFeat;
    logic clearReq, failMode, abortCmd, accept;
    logic [7:0] errCode;
    logic completedOk_d;
    logic [15:0] progressOut;

    sfl_sanitize_engine #(
        .TICK_CYCLES(TICK_CYCLES),
        .PROG_STEP(PROG_STEP)
    ) engine (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(accept && isStart),
        .mediaFault(mediaFault),
        .busy_q(engBusy),
        .done_q(engDone),
        .failed_q(engFailed),
        .progress_q(engProgress)
    );

    assign isSan = cmdValid && (cmd.code == `SFL_CMD_SANITIZE);
    assign isStatus = (cmd.feature == `SFL_FEAT_STATUS);
    assign isFreeze = (cmd.feature == `SFL_FEAT_FREEZE);
    assign isOverwrite = (cmd.feature == `SFL_FEAT_OVERWRITE);
    assign isCrypto = (cmd.feature == `SFL_FEAT_CRYPTO);
    assign isStart = isOverwrite || isCrypto;
    assign knownFeat = isStatus || isFreeze || isStart;
    assign clearReq = cmd.count[`SFL_SC_CLEAR_BIT];
    assign failMode = cmd.count[`SFL_SC_FAILMODE_BIT];

    // Abort decision; frozen checks come before any other state check
    always_comb begin
        abortCmd = 1'b0;
        errCode = `SFL_ERRC_NONE;
        if (!knownFeat) begin
            abortCmd = 1'b1;
            errCode = `SFL_ERRC_BAD_FEATURE;
        end else if (state_q == sanitize_frozen_state && !isStatus) begin
            abortCmd = 1'b1;
            errCode = `SFL_ERRC_FROZEN;
        end else if (state_q == sanitize_operation_state && !isStatus) begin
            abortCmd = 1'b1;
        end else if (state_q == sanitize_failed_state) begin
            if (!exitAllowed_q && (!isStatus || clearReq)) begin
                abortCmd = 1'b1;
            end else if (isOverwrite && failMode) begin
                abortCmd = 1'b1;
            end
        end
    end

    assign accept = isSan && !abortCmd;

    always_comb begin
        state_d = state_q;
        if (hwReset && state_q == sanitize_frozen_state) begin
            state_d = sanitize_idle_state;
        end else if (engDone) begin
            state_d = engFailed ? sanitize_failed_state : sanitize_succeeded_state;
        end else if (accept && isFreeze) begin
            state_d = sanitize_frozen_state;
        end else if (accept && isStart) begin
            state_d = sanitize_operation_state;
        end else if (accept && isStatus && clearReq && state_q == sanitize_failed_state) begin
            state_d = sanitize_idle_state;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= sanitize_idle_state;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exitAllowed_q <= 1'b0;
        end else if (accept && isStart) begin
            exitAllowed_q <= failMode;
        end
    end

    // The flag lives in external persistent storage; it is reloaded on the
    // first edge after reset so a power cycle does not lose it.
    always_comb begin
        completedOk_d = completedOk_q;
        if (!nvLoaded_q) begin
            completedOk_d = nvCompletedIn;
        end else if (engDone && !engFailed) begin
            completedOk_d = 1'b1;
        end else if (accept && isStart) begin
            completedOk_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvLoaded_q <= 1'b0;
            completedOk_q <= 1'b0;
        end else begin
            nvLoaded_q <= 1'b1;
            completedOk_q <= completedOk_d;
        end
    end

    // Progress is zero on the entry cycle since the engine starts from zero
    assign progressOut = (state_d == sanitize_operation_state) ?
        ((state_q == sanitize_operation_state) ? engProgress : 16'h0000) : `SFL_PROGRESS_IDLE;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmdDone_q <= 1'b0;
            resp_q <= '0;
        end else begin
            cmdDone_q <= isSan;
            if (isSan) begin
                resp_q.commandStatusFlags <= 8'h00;
                resp_q.commandStatusFlags[`SFL_ST_READY_BIT] <= 1'b1;
                resp_q.commandStatusFlags[`SFL_ST_SEEK_BIT] <= 1'b1;
                resp_q.commandStatusFlags[`SFL_ST_BUSY_BIT] <= 1'b0;
                resp_q.commandStatusFlags[`SFL_ST_ERR_BIT] <= abortCmd;
                resp_q.commandErrorFlags <= 8'h00;
                resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT] <= abortCmd;
                resp_q.secCount <= 16'h0000;
                resp_q.secCount[`SFL_SC_DONE_BIT] <= completedOk_d;
                resp_q.secCount[`SFL_SC_RUN_BIT] <= (state_d == sanitize_operation_state);
                resp_q.secCount[`SFL_SC_FROZEN_BIT] <= (state_d == sanitize_frozen_state);
                if (abortCmd) begin
                    resp_q.secNum <= errCode;
                    resp_q.cylLow <= progressOut[15:8];
                end else if (isStatus && state_q == sanitize_failed_state && !exitAllowed_q) begin
                    // Reason for the failure is reported to a plain status query
                    resp_q.secNum <= `SFL_ERRC_UNSANITIZED;
                    resp_q.cylLow <= progressOut[15:8];
                end else begin
                    resp_q.secNum <= progressOut[7:0];
                    resp_q.cylLow <= progressOut[15:8];
                end
            end
        end
    end

    sequence s_freezeTaken;
        isSan && isFreeze && !abortCmd && !engDone;
    endsequence

    sequence s_frozenAnswer;
        cmdDone_q && resp_q.secCount[`SFL_SC_FROZEN_BIT] && !resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT];
    endsequence

    property p_freezeEnter;
        @(posedge ref_clk) disable iff (sys_rst)
        s_freezeTaken |=> s_frozenAnswer ##0 (state_q == sanitize_frozen_state);
    endproperty
    a_freezeEnter: assert property (p_freezeEnter) else $error("freeze-lock did not enter frozen");

    property p_frozenAbort;
        @(posedge ref_clk) disable iff (sys_rst)
        (isSan && !isStatus && knownFeat && state_q == sanitize_frozen_state) |=>
            cmdDone_q && resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT] && resp_q.secNum == 8'h03;
    endproperty
    a_frozenAbort: assert property (p_frozenAbort) else $error("frozen did not abort sanitize command");

    property p_frozenHold;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_q == sanitize_frozen_state && !hwReset) |=> (state_q == sanitize_frozen_state);
    endproperty
    a_frozenHold: assert property (p_frozenHold) else $error("frozen state left without reset");

    property p_hwExit;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_q == sanitize_frozen_state && hwReset) |=> (state_q == sanitize_idle_state);
    endproperty
    a_hwExit: assert property (p_hwExit) else $error("hardware reset did not leave frozen");

    property p_failedAbort;
        @(posedge ref_clk) disable iff (sys_rst)
        // Only overwrite is refused for a set failed_state_exit_allowed bit; crypto with it set is a legal restart only while exitAllowed_q is one
        (isSan && isStart && state_q == sanitize_failed_state
            && (!exitAllowed_q || (isOverwrite && failMode))) |=>
            resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT] && (state_q == sanitize_failed_state);
    endproperty
    a_failedAbort: assert property (p_failedAbort) else $error("failed state accepted a start");

    property p_startClears;
        @(posedge ref_clk) disable iff (sys_rst)
        (accept && isStart && nvLoaded_q) |=> !completedOk_q && resp_q.secCount[15:13] == 3'b010;
    endproperty
    a_startClears: assert property (p_startClears) else $error("start did not clear done flag");

    property p_idleProgress;
        @(posedge ref_clk) disable iff (sys_rst)
        (cmdDone_q && !resp_q.secCount[`SFL_SC_RUN_BIT] && !resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT]
            && !(resp_q.secNum == 8'h01)) |-> {resp_q.cylLow, resp_q.secNum} == 16'hffff;
    endproperty
    a_idleProgress: assert property (p_idleProgress) else $error("progress not FFFFh when idle");

    property p_abortFlags;
        @(posedge ref_clk) disable iff (sys_rst)
        (isSan && abortCmd) |=> cmdDone_q && resp_q.commandStatusFlags[`SFL_ST_ERR_BIT]
            && !resp_q.commandStatusFlags[`SFL_ST_BUSY_BIT] && resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT];
    endproperty
    a_abortFlags: assert property (p_abortFlags) else $error("abort flags wrong");

    property p_clearExit;
        @(posedge ref_clk) disable iff (sys_rst)
        (isSan && isStatus && clearReq && exitAllowed_q && state_q == sanitize_failed_state) |=>
            (state_q == sanitize_idle_state) && !resp_q.commandErrorFlags[`SFL_ERR_ABORT_BIT];
    endproperty
    a_clearExit: assert property (p_clearExit) else $error("clear did not return to idle");

    // The engine may only run while the in-progress bit can be reported
    property p_busyInOp;
        @(posedge ref_clk) disable iff (sys_rst)
        engBusy |-> (state_q == sanitize_operation_state);
    endproperty
    a_busyInOp: assert property (p_busyInOp) else $error("engine busy outside operation state");

endmodule

// [test/sfl_host_model.sv]
`timescale 1ns/1ps
module sfl_host_model
    import sfl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic cmdDone_q,
    input wire sfl_resp_type resp_q,
    output logic cmdValid,
    output sfl_cmd_type cmd
);
    sfl_resp_type lastResp;
    logic gotAnswer;

    initial begin
        cmdValid = 1'b0;
        cmd = '0;
        lastResp = '0;
        gotAnswer = 1'b0;
    end

    // One-cycle request; the answer is awaited for a few cycles only, so a silent device is caught
    task automatic issue(input logic [7:0] code, input logic [15:0] feature, input logic [15:0] count);
        int n;
        n = 0;
        gotAnswer = 1'b0;
        @(negedge ref_clk);
        cmdValid = 1'b1;
        cmd = {code, feature, count};
        @(negedge ref_clk);
        cmdValid = 1'b0;
        // Released lines show the inverse so a stale sample cannot pass
        cmd = ~cmd;
        while (cmdDone_q !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        gotAnswer = (cmdDone_q === 1'b1);
        lastResp = resp_q;
    endtask
endmodule

// [test/sanitize_freeze_lock_status_tb.sv]
`timescale 1ns/1ps
`include "sfl_defines.svh"
module sanitize_freeze_lock_status_tb
    import sfl_pkg::*;
;
    localparam logic [15:0] FEAT_BAD = 16'h0033;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hwReset = 1'b0;
    logic mediaFault = 1'b0;
    logic nvStore = 1'b0;
    logic cmdValid;
    logic cmdDone_q;
    logic completedOk_q;
    sfl_cmd_type cmd;
    sfl_resp_type resp_q;
    int badCount = 0;
    int nTests = 0;
    int cycles = 0;

    always #25 ref_clk = ~ref_clk;

    // Short ticks and big steps keep an operation to about 16 cycles, one tick per cycle
    sfl_sanitize_ctrl #(.TICK_CYCLES(1), .PROG_STEP(16'h1000)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hwReset(hwReset),
        .cmdValid(cmdValid), .cmd(cmd), .mediaFault(mediaFault),
        .nvCompletedIn(nvStore), .cmdDone_q(cmdDone_q), .resp_q(resp_q),
        .completedOk_q(completedOk_q));

    sfl_host_model u_host (.ref_clk(ref_clk), .cmdDone_q(cmdDone_q), .resp_q(resp_q),
        .cmdValid(cmdValid), .cmd(cmd));

    task automatic wrapUp();
        $display("Checks %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            badCount++;
            wrapUp();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic req(input logic [15:0] feat, input logic [15:0] cnt, input logic ab,
                       input logic [2:0] sc, input logic [15:0] prog, input logic [15:0] pm);
        sfl_resp_type r;
        u_host.issue(`SFL_CMD_SANITIZE, feat, cnt);
        r = u_host.lastResp;
        chk({15'h0, u_host.gotAnswer}, 16'h1);
        chk({r.commandStatusFlags, r.commandErrorFlags}, ab ? 16'h5104 : 16'h5000);
        chk({13'h0, r.secCount[15:13]}, {13'h0, sc});
        chk({r.cylLow, r.secNum} & pm, prog & pm);
    endtask

    // The persistent store is modelled here: it keeps the flag across the reset
    task automatic powerCycle();
        @(negedge ref_clk);
        nvStore = completedOk_q;
        sys_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic tIdle();
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b000, 16'hffff, 16'hffff);
        u_host.issue(8'hec, `SFL_FEAT_STATUS, 16'h0);
        chk({15'h0, u_host.gotAnswer}, 16'h0);
        req(FEAT_BAD, 16'h0, 1'b1, 3'b000, {8'h0, `SFL_ERRC_BAD_FEATURE}, 16'h00ff);
    endtask

    task automatic tOverwrite();
        req(`SFL_FEAT_OVERWRITE, 16'h0, 1'b0, 3'b010, 16'h0000, 16'hffff);
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b010, 16'h0, 16'h0);
        req(`SFL_FEAT_CRYPTO, 16'h0, 1'b1, 3'b010, 16'h0, 16'h00ff);
        repeat (30) @(negedge ref_clk);
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b100, 16'hffff, 16'hffff);
        chk({15'h0, completedOk_q}, 16'h1);
        powerCycle();
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b100, 16'hffff, 16'hffff);
    endtask

    task automatic tFailed();
        mediaFault = 1'b1;
        req(`SFL_FEAT_OVERWRITE, 16'h0, 1'b0, 3'b010, 16'h0, 16'hffff);
        repeat (30) @(negedge ref_clk);
        mediaFault = 1'b0;
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b000, 16'h0001, 16'h00ff);
        req(`SFL_FEAT_OVERWRITE, 16'h0010, 1'b1, 3'b000, 16'h0, 16'h00ff);
        req(`SFL_FEAT_STATUS, 16'h0001, 1'b1, 3'b000, 16'h0, 16'h00ff);
        powerCycle();
        mediaFault = 1'b1;
        req(`SFL_FEAT_OVERWRITE, 16'h0010, 1'b0, 3'b010, 16'h0, 16'hffff);
        repeat (30) @(negedge ref_clk);
        mediaFault = 1'b0;
        req(`SFL_FEAT_OVERWRITE, 16'h0010, 1'b1, 3'b000, 16'h0, 16'h00ff);
        req(`SFL_FEAT_STATUS, 16'h0001, 1'b0, 3'b000, 16'h0, 16'h0);
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b000, 16'hffff, 16'hffff);
    endtask

    task automatic tFreeze();
        logic [15:0] feats [3] = '{`SFL_FEAT_OVERWRITE, `SFL_FEAT_CRYPTO, `SFL_FEAT_FREEZE};
        req(`SFL_FEAT_FREEZE, 16'h0, 1'b0, 3'b001, 16'hffff, 16'hffff);
        foreach (feats[i]) begin
            req(feats[i], 16'h0010, 1'b1, 3'b001, {8'h0, `SFL_ERRC_FROZEN}, 16'h00ff);
        end
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b001, 16'hffff, 16'hffff);
        req(`SFL_FEAT_STATUS, 16'h0001, 1'b0, 3'b001, 16'hffff, 16'hffff);
        @(negedge ref_clk);
        hwReset = 1'b1;
        @(negedge ref_clk);
        hwReset = 1'b0;
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b000, 16'hffff, 16'hffff);
        req(`SFL_FEAT_FREEZE, 16'h0, 1'b0, 3'b001, 16'hffff, 16'hffff);
        powerCycle();
        req(`SFL_FEAT_STATUS, 16'h0, 1'b0, 3'b000, 16'hffff, 16'hffff);
    endtask

    initial begin
        powerCycle();
        tIdle();
        tOverwrite();
        tFailed();
        tFreeze();
        wrapUp();
    end
endmodule
